// ### rtl/oag_addr_gen.sv
// Operand fetch and effective address generation for the 8-bit core
// Notes on behaviour
// RQ1: An inherent instruction is the opcode byte alone with no operand fetch.
// RQ2: An immediate instruction is two bytes, the second being the operand value.
// RQ3: Short direct fetches one address byte, reaching 00 to FF only.
// RQ4: Long direct fetches a two-byte address reaching the whole 64 Kbyte space.
// RQ5: Indexed address is the unsigned sum of the chosen index register and the offset.
// RQ6: No-offset indexed fetches no byte and uses the index register alone.
// RQ7: Short indexed adds a one-byte offset unsigned, reaching 00 to 1FE.
// RQ8: Long indexed adds a two-byte offset, reaching the whole 64 Kbyte space.
// RQ9: Indirect modes read a pointer from the page-zero location after the opcode.
// RQ10: Short indirect uses a one-byte pointer, long indirect a two-byte pointer.
// RQ11: Indirect indexed adds the index register to the pointer read from memory.
// RQ12: Relative jumps add a signed byte to the address of the next instruction.
// RQ13: Read-modify-write opcode groups only ever decode to short forms.
// RQ14: No-offset indexed costs no byte with the first index, one with the second.
// RQ15: Prefix 90 swaps the second index register in for the first.
// RQ16: Prefix 92 turns direct and first-index forms into their indirect forms.
// RQ17: Words are fetched high byte first, operand bytes in ascending order.
`timescale 1ns/10ps
module oag_addr_gen (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire oag_pkg::oag_req_t req_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic mem_valid_in,
  output logic mem_req_out,
  output logic [15:0] mem_addr_out,
  output logic busy_out,
  output logic done_out,
  output oag_pkg::oag_res_t result_out
);
  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  // Opcode group sits in the upper nibble; groups 0,1,3,6,7 are the
  // read-modify-write ones and never get a long form.
  function automatic oag_pkg::oag_mode_t mode_of(input logic [7:0] op, input logic ind);
    oag_pkg::oag_mode_t m;
    m = oag_pkg::M_INH;
    case (op[7:4])
      4'h0: m = ind ? oag_pkg::M_BITREL_IND : oag_pkg::M_BITREL;
      4'h1: m = ind ? oag_pkg::M_BIT_IND : oag_pkg::M_BIT;
      4'h2: m = ind ? oag_pkg::M_REL_IND : oag_pkg::M_REL;
      4'h3, 4'hB: m = ind ? oag_pkg::M_IND_S : oag_pkg::M_DIR_S; // see RQ13 RQ16
      4'h6, 4'hE: m = ind ? oag_pkg::M_IIDX_S : oag_pkg::M_IDX_S; // see RQ13 RQ16
      4'h7, 4'hF: m = oag_pkg::M_IDX0;
      4'hA: m = oag_pkg::M_IMM;
      4'hC: m = ind ? oag_pkg::M_IND_L : oag_pkg::M_DIR_L; // see RQ16
      4'hD: m = ind ? oag_pkg::M_IIDX_L : oag_pkg::M_IDX_L; // see RQ16
      default: m = oag_pkg::M_INH; // see RQ1
    endcase
    return m;
  endfunction : mode_of

  function automatic oag_pkg::oag_attr_t attr_of(input oag_pkg::oag_mode_t m);
    oag_pkg::oag_attr_t a;
    a = '0;
    a.narg = 2'h1; // see RQ2 RQ3 RQ7
    case (m)
      oag_pkg::M_INH: a.narg = 2'h0; // see RQ1
      oag_pkg::M_IDX0: begin
        a.narg = 2'h0; // see RQ6 RQ14
        a.idx = 1'b1;
      end
      oag_pkg::M_DIR_L: a.narg = 2'h2; // see RQ4
      oag_pkg::M_IDX_S: a.idx = 1'b1;
      oag_pkg::M_IDX_L: begin
        a.narg = 2'h2; // see RQ8
        a.idx = 1'b1;
      end
      oag_pkg::M_IND_S, oag_pkg::M_BIT_IND: a.nptr = 2'h1; // see RQ10
      oag_pkg::M_IND_L: a.nptr = 2'h2; // see RQ10
      oag_pkg::M_IIDX_S: begin
        a.nptr = 2'h1; // see RQ11
        a.idx = 1'b1;
      end
      oag_pkg::M_IIDX_L: begin
        a.nptr = 2'h2; // see RQ11
        a.idx = 1'b1;
      end
      oag_pkg::M_REL: a.rel = 1'b1;
      oag_pkg::M_REL_IND: begin
        a.nptr = 2'h1;
        a.rel = 1'b1;
        a.rel_ptr = 1'b1;
      end
      oag_pkg::M_BITREL: begin
        a.disp_code = 1'b1;
        a.rel = 1'b1;
      end
      oag_pkg::M_BITREL_IND: begin
        a.disp_code = 1'b1;
        a.rel = 1'b1;
        a.nptr = 2'h1;
      end
      default: a.narg = 2'h1;
    endcase
    return a;
  endfunction : attr_of

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  oag_pkg::oag_state_t state;
  oag_pkg::oag_mode_t mode;
  logic [15:0] pc;
  logic [15:0] start_pc;
  logic [7:0] x_reg;
  logic [7:0] y_reg;
  logic ysel;
  logic ind;
  logic pfx_seen;
  logic [7:0] opcode;
  logic [15:0] arg;
  logic [15:0] ptr;
  logic [7:0] disp;
  logic [1:0] cnt;

  wire oag_pkg::oag_mode_t dec_mode = mode_of(mem_rdata_in, ind);
  wire oag_pkg::oag_attr_t dec_attr = attr_of(dec_mode);
  wire oag_pkg::oag_attr_t cur_attr = attr_of(mode);
  wire take = mem_req_out && mem_valid_in;
  wire [15:0] pc_inc = pc + 16'h0001;
  wire is_pfx_y = !pfx_seen && mem_rdata_in == oag_pkg::PFX_SECOND_INDEX; // see RQ15
  wire is_pfx_i = !pfx_seen && mem_rdata_in == oag_pkg::PFX_INDIRECT; // see RQ16
  wire arg_last = cnt == cur_attr.narg - 2'h1;
  wire ptr_last = cnt == cur_attr.nptr - 2'h1;
  // Pointer stays in page zero; a word pointer at FF wraps to 00.
  wire [15:0] ptr_loc = {oag_pkg::PAGE0_HIGH, arg[7:0]}; // see RQ9
  wire [15:0] ptr_loc_hi = {oag_pkg::PAGE0_HIGH, arg[7:0] + 8'h01};
  wire [15:0] shifted_arg = {arg[7:0], mem_rdata_in}; // see RQ17
  wire [15:0] shifted_ptr = {ptr[7:0], mem_rdata_in}; // see RQ17

  // ---------------------------------------------------------------
  // Address arithmetic
  // ---------------------------------------------------------------
  wire [7:0] idx_val = ysel ? y_reg : x_reg; // see RQ15
  wire [15:0] base = (cur_attr.nptr != 2'h0) ? ptr : arg; // see RQ9
  wire [15:0] idx_sum = base + {8'h00, idx_val}; // see RQ5 RQ11
  wire [7:0] rel_disp = cur_attr.rel_ptr ? ptr[7:0] : (cur_attr.disp_code ? disp : arg[7:0]);
  wire [15:0] rel_tgt = pc + {{8{rel_disp[7]}}, rel_disp}; // see RQ12
  wire [15:0] ea_val = cur_attr.idx ? idx_sum : ((mode == oag_pkg::M_REL ||
      mode == oag_pkg::M_REL_IND) ? rel_tgt : base);
  wire [15:0] len_full = pc - start_pc;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= oag_pkg::S_IDLE;
      mode <= oag_pkg::M_INH;
      pc <= 16'h0000;
      start_pc <= 16'h0000;
      x_reg <= 8'h00;
      y_reg <= 8'h00;
      ysel <= 1'b0;
      ind <= 1'b0;
      pfx_seen <= 1'b0;
      opcode <= 8'h00;
      arg <= 16'h0000;
      ptr <= 16'h0000;
      disp <= 8'h00;
      cnt <= 2'h0;
      mem_req_out <= 1'b0;
      mem_addr_out <= 16'h0000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      result_out <= '0;
    end else begin
      done_out <= 1'b0;
      case (state)
        oag_pkg::S_IDLE: begin
          if (start_in) begin
            pc <= req_in.pc;
            start_pc <= req_in.pc;
            x_reg <= req_in.x;
            y_reg <= req_in.y;
            ysel <= 1'b0;
            ind <= 1'b0;
            pfx_seen <= 1'b0;
            mem_req_out <= 1'b1;
            mem_addr_out <= req_in.pc;
            busy_out <= 1'b1;
            state <= oag_pkg::S_OP;
          end
        end
        oag_pkg::S_OP: begin
          if (take) begin
            pc <= pc_inc;
            mem_addr_out <= pc_inc;
            if (is_pfx_y || is_pfx_i) begin
              pfx_seen <= 1'b1;
              ysel <= is_pfx_y; // see RQ15
              ind <= is_pfx_i; // see RQ16
            end else begin
              opcode <= mem_rdata_in;
              mode <= dec_mode;
              arg <= 16'h0000;
              ptr <= 16'h0000;
              cnt <= 2'h0;
              if (dec_attr.narg != 2'h0) begin
                state <= oag_pkg::S_ARG;
              end else begin
                mem_req_out <= 1'b0; // see RQ1 RQ6
                state <= oag_pkg::S_CALC;
              end
            end
          end
        end
        oag_pkg::S_ARG: begin
          if (take) begin
            arg <= shifted_arg; // see RQ17
            pc <= pc_inc;
            cnt <= arg_last ? 2'h0 : cnt + 2'h1;
            if (!arg_last) begin
              mem_addr_out <= pc_inc;
            end else if (cur_attr.disp_code) begin
              mem_addr_out <= pc_inc;
              state <= oag_pkg::S_DISP;
            end else if (cur_attr.nptr != 2'h0) begin
              mem_addr_out <= {oag_pkg::PAGE0_HIGH, mem_rdata_in}; // see RQ9
              state <= oag_pkg::S_PTR;
            end else begin
              mem_req_out <= 1'b0;
              state <= oag_pkg::S_CALC;
            end
          end
        end
        oag_pkg::S_DISP: begin
          if (take) begin
            disp <= mem_rdata_in;
            pc <= pc_inc;
            if (cur_attr.nptr != 2'h0) begin
              mem_addr_out <= ptr_loc;
              state <= oag_pkg::S_PTR;
            end else begin
              mem_req_out <= 1'b0;
              state <= oag_pkg::S_CALC;
            end
          end
        end
        oag_pkg::S_PTR: begin
          if (take) begin
            ptr <= shifted_ptr; // see RQ10 RQ17
            cnt <= cnt + 2'h1;
            mem_addr_out <= ptr_loc_hi;
            if (ptr_last) begin
              mem_req_out <= 1'b0;
              state <= oag_pkg::S_CALC;
            end
          end
        end
        oag_pkg::S_CALC: begin
          result_out.ea <= ea_val;
          result_out.target <= rel_tgt;
          result_out.opcode <= opcode;
          result_out.mode <= mode;
          result_out.imm <= arg[7:0]; // see RQ2
          result_out.len <= len_full[2:0];
          result_out.ysel <= ysel;
          result_out.ind <= ind;
          done_out <= 1'b1;
          busy_out <= 1'b0;
          state <= oag_pkg::S_IDLE;
        end
        default: begin
          mem_req_out <= 1'b0;
          busy_out <= 1'b0;
          state <= oag_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  wire [2:0] pfx_n = {2'h0, result_out.ysel} + {2'h0, result_out.ind};
  wire [15:0] end_pc = start_pc + {13'h0000, result_out.len};
  wire [15:0] rel_gap = result_out.target - end_pc;
  wire rmw_grp = result_out.opcode[7:4] inside {4'h0, 4'h1, 4'h3, 4'h6, 4'h7};

  a_inh_length: assert property (done_out && result_out.mode == oag_pkg::M_INH // see RQ1
    |-> result_out.len == 3'h1 + pfx_n) else $error("inherent length wrong");
  a_imm_length: assert property (done_out && result_out.mode == oag_pkg::M_IMM // see RQ2
    |-> result_out.len == 3'h2 + pfx_n) else $error("immediate length wrong");
  a_dir_short: assert property (done_out && result_out.mode == oag_pkg::M_DIR_S // see RQ3
    |-> result_out.ea <= oag_pkg::PAGE0_LAST) else $error("short direct out of page");
  a_dir_long: assert property (done_out && result_out.mode == oag_pkg::M_DIR_L // see RQ4
    |-> result_out.len == 3'h3 + pfx_n) else $error("long direct length wrong");
  a_idx_none: assert property (done_out && result_out.mode == oag_pkg::M_IDX0 // see RQ6 RQ14
    |-> result_out.ea == {8'h00, idx_val} && result_out.len == 3'h1 + pfx_n)
    else $error("no-offset indexed wrong");
  a_idx_short: assert property (done_out && result_out.mode inside // see RQ7 RQ11
    {oag_pkg::M_IDX_S, oag_pkg::M_IIDX_S} |-> result_out.ea <= oag_pkg::SHORT_IDX_LAST)
    else $error("short indexed out of range");
  a_ptr_page: assert property (state == oag_pkg::S_PTR && mem_req_out // see RQ9
    |-> mem_addr_out[15:8] == oag_pkg::PAGE0_HIGH) else $error("pointer off page zero");
  a_rel_range: assert property (done_out && result_out.mode == oag_pkg::M_REL // see RQ12
    |-> (rel_gap <= oag_pkg::REL_FWD || rel_gap >= 16'h0000 - oag_pkg::REL_BACK))
    else $error("relative target out of reach");
  a_rmw_short: assert property (done_out && rmw_grp |-> !(result_out.mode inside // see RQ13
    {oag_pkg::M_DIR_L, oag_pkg::M_IDX_L, oag_pkg::M_IND_L, oag_pkg::M_IIDX_L}))
    else $error("long form on read-modify-write");
  a_pfx_second: assert property (state == oag_pkg::S_OP && take && is_pfx_y // see RQ15
    |=> ysel ##1 (ysel throughout (state != oag_pkg::S_IDLE)[*1]))
    else $error("second index prefix lost");
  a_pfx_ind: assert property (done_out && result_out.ind // see RQ16
    && result_out.opcode[7:4] == 4'hB |-> result_out.mode == oag_pkg::M_IND_S)
    else $error("indirect prefix not applied");
  a_arg_order: assert property (state == oag_pkg::S_ARG && take && !arg_last // see RQ17
    |=> mem_addr_out == $past(mem_addr_out) + 16'h0001) else $error("operand order wrong");

  c_long_ind: cover property (done_out && result_out.mode == oag_pkg::M_IIDX_L);
  c_bitrel_ind: cover property (done_out && result_out.mode == oag_pkg::M_BITREL_IND);
  c_rel_back: cover property (done_out && result_out.mode == oag_pkg::M_REL && rel_gap[15]);
  c_y_idx: cover property (done_out && result_out.ysel && result_out.mode == oag_pkg::M_IDX0);
endmodule : oag_addr_gen

// ### rtl/oag_pkg.sv
// Shared constants and types for the operand address generator
package oag_pkg;
  // ---------------------------------------------------------------
  // Prefix bytes and address limits
  // ---------------------------------------------------------------
  localparam logic [7:0] PFX_SECOND_INDEX = 8'h90;
  localparam logic [7:0] PFX_INDIRECT = 8'h92;
  localparam logic [15:0] PAGE0_LAST = 16'h00FF;
  localparam logic [15:0] SHORT_IDX_LAST = 16'h01FE;
  localparam logic [7:0] PAGE0_HIGH = 8'h00;
  localparam logic [15:0] REL_BACK = 16'h0080;
  localparam logic [15:0] REL_FWD = 16'h007F;

  // ---------------------------------------------------------------
  // Addressing modes and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    M_INH = 5'h00, M_IMM = 5'h01, M_DIR_S = 5'h02, M_DIR_L = 5'h03,
    M_IDX0 = 5'h04, M_IDX_S = 5'h05, M_IDX_L = 5'h06, M_IND_S = 5'h07,
    M_IND_L = 5'h08, M_IIDX_S = 5'h09, M_IIDX_L = 5'h0A, M_REL = 5'h0B,
    M_REL_IND = 5'h0C, M_BIT = 5'h0D, M_BIT_IND = 5'h0E, M_BITREL = 5'h0F,
    M_BITREL_IND = 5'h10
  } oag_mode_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_OP = 3'h1, S_ARG = 3'h2, S_DISP = 3'h3, S_PTR = 3'h4,
    S_CALC = 3'h5
  } oag_state_t;

  // Fetch shape of one mode
  typedef struct packed {
    logic [1:0] narg;
    logic [1:0] nptr;
    logic idx;
    logic disp_code;
    logic rel;
    logic rel_ptr;
  } oag_attr_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] y;
  } oag_req_t;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] target;
    logic [7:0] opcode;
    oag_mode_t mode;
    logic [7:0] imm;
    logic [2:0] len;
    logic ysel;
    logic ind;
  } oag_res_t;
endpackage : oag_pkg

// ### tb/cpu_operand_address_generator_bench.sv
// Self-checking bench for the operand address generator
`timescale 1ns/10ps
module cpu_operand_address_generator_bench;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic start_in = 1'b0;
  logic slow = 1'b0;
  oag_pkg::oag_req_t req_in = '0;
  logic [7:0] mem_rdata;
  logic mem_valid;
  logic mem_req;
  logic [15:0] mem_addr;
  logic busy;
  logic done;
  oag_pkg::oag_res_t res;
  int error_cnt = 0;
  int n_tests = 0;
  int takes;

  oag_addr_gen dut_u (.clk_in(clk_in), .reset_in(reset_in), .start_in(start_in),
    .req_in(req_in), .mem_rdata_in(mem_rdata), .mem_valid_in(mem_valid),
    .mem_req_out(mem_req), .mem_addr_out(mem_addr), .busy_out(busy), .done_out(done),
    .result_out(res));
  oag_mem_model mem_u (.clk_in(clk_in), .slow_in(slow), .mem_req_in(mem_req),
    .mem_addr_in(mem_addr), .mem_rdata_out(mem_rdata), .mem_valid_out(mem_valid));

  initial begin
    forever #2 clk_in = ~clk_in;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    mem_u.mem[a] = d;
  endtask : put

  // Start given in the previous done cycle when called back to back
  task automatic run(input logic [15:0] pc, input logic [7:0] x, input logic [7:0] y);
    int i;
    takes = mem_u.n_take;
    start_in = 1'b1;
    req_in = {pc, x, y};
    @(posedge clk_in);
    #1;
    start_in = 1'b0;
    chk("busy", 16'h0001, {15'h0000, busy});
    for (i = 0; i < 200; i++) begin
      @(posedge clk_in);
      #1;
      if (done === 1'b1) break;
    end
    chk("done", 16'h0001, {15'h0000, done});
    chk("busy at done", 16'h0000, {15'h0000, busy});
    takes = mem_u.n_take - takes;
  endtask : run

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_reset;
    chk("req after reset", 16'h0000, {15'h0000, mem_req});
    chk("busy after reset", 16'h0000, {15'h0000, busy});
    chk("ea after reset", 16'h0000, res.ea);
  endtask : s_reset

  task automatic s_inh_imm;
    put(16'h0100, 8'h40);
    run(16'h0100, 8'h00, 8'h00);
    chk("inh mode", 16'(oag_pkg::M_INH), 16'(res.mode));
    chk("inh takes", 16'h0001, 16'(takes));
    put(16'h0110, 8'hA6);
    put(16'h0111, 8'h55);
    run(16'h0110, 8'h00, 8'h00);
    chk("imm value", 16'h0055, 16'(res.imm));
    chk("imm len", 16'h0002, 16'(res.len));
  endtask : s_inh_imm

  task automatic s_direct;
    put(16'h0120, 8'h3B);
    put(16'h0121, 8'h80);
    run(16'h0120, 8'h00, 8'h00);
    chk("dir short ea", 16'h0080, res.ea);
    put(16'h0130, 8'hC6);
    put(16'h0131, 8'h12);
    put(16'h0132, 8'h34);
    run(16'h0130, 8'h00, 8'h00);
    chk("dir long ea", 16'h1234, res.ea);
    chk("dir long len", 16'h0003, 16'(res.len));
    chk("dir long last addr", 16'h0132, mem_u.last_addr);
  endtask : s_direct

  task automatic s_indexed;
    put(16'h0140, 8'hF6);
    run(16'h0140, 8'hFF, 8'h42);
    chk("idx0 x ea", 16'h00FF, res.ea);
    chk("idx0 x takes", 16'h0001, 16'(takes));
    put(16'h0150, oag_pkg::PFX_SECOND_INDEX);
    put(16'h0151, 8'hF6);
    run(16'h0150, 8'hFF, 8'h42);
    chk("idx0 y ea", 16'h0042, res.ea);
    chk("idx0 y len", 16'h0002, 16'(res.len));
    chk("idx0 y sel", 16'h0001, {15'h0000, res.ysel});
    put(16'h0160, 8'hE6);
    put(16'h0161, 8'hFF);
    run(16'h0160, 8'hFF, 8'h00);
    chk("idx short ea", 16'h01FE, res.ea);
    put(16'h0170, 8'hD6);
    put(16'h0171, 8'hFF);
    put(16'h0172, 8'h00);
    run(16'h0170, 8'hFF, 8'h00);
    chk("idx long ea", 16'hFFFF, res.ea);
  endtask : s_indexed

  task automatic s_indirect;
    put(16'h0180, oag_pkg::PFX_INDIRECT);
    put(16'h0181, 8'h3B);
    put(16'h0182, 8'h40);
    put(16'h0040, 8'h77);
    run(16'h0180, 8'h00, 8'h00);
    chk("ind short ea", 16'h0077, res.ea);
    chk("ind short mode", 16'(oag_pkg::M_IND_S), 16'(res.mode));
    chk("ind short flag", 16'h0001, {15'h0000, res.ind});
    chk("ind short opcode", 16'h003B, 16'(res.opcode));
    put(16'h0190, oag_pkg::PFX_INDIRECT);
    put(16'h0191, 8'hC6);
    put(16'h0192, 8'hFF);
    put(16'h00FF, 8'hAB);
    put(16'h0000, 8'hCD);
    run(16'h0190, 8'h00, 8'h00);
    chk("ind long ea", 16'hABCD, res.ea);
    chk("ind long takes", 16'h0005, 16'(takes));
    chk("ind long wrap addr", 16'h0000, mem_u.last_addr);
    put(16'h01A0, oag_pkg::PFX_INDIRECT);
    put(16'h01A1, 8'hE6);
    put(16'h01A2, 8'h50);
    put(16'h0050, 8'hFF);
    run(16'h01A0, 8'hFF, 8'h00);
    chk("ind idx ea", 16'h01FE, res.ea);
  endtask : s_indirect

  task automatic s_relative;
    slow = 1'b1;
    put(16'h0200, 8'h20);
    put(16'h0201, 8'h80);
    run(16'h0200, 8'h00, 8'h00);
    chk("rel back", 16'h0182, res.ea);
    put(16'h0210, 8'h20);
    put(16'h0211, 8'h7F);
    run(16'h0210, 8'h00, 8'h00);
    chk("rel fwd", 16'h0291, res.ea);
    slow = 1'b0;
  endtask : s_relative

  task automatic s_bit;
    put(16'h0220, 8'h10);
    put(16'h0221, 8'h33);
    run(16'h0220, 8'h00, 8'h00);
    chk("bit ea", 16'h0033, res.ea);
    put(16'h0230, 8'h00);
    put(16'h0231, 8'h10);
    put(16'h0232, 8'hF0);
    run(16'h0230, 8'h00, 8'h00);
    chk("bitrel ea", 16'h0010, res.ea);
    chk("bitrel target", 16'h0223, res.target);
  endtask : s_bit

  task automatic s_ind_more;
    put(16'h0240, oag_pkg::PFX_INDIRECT);
    put(16'h0241, 8'hD6);
    put(16'h0242, 8'h60);
    put(16'h0060, 8'h12);
    put(16'h0061, 8'h34);
    run(16'h0240, 8'h10, 8'h00);
    chk("ind idx long ea", 16'h1244, res.ea);
    chk("ind idx long len", 16'h0003, 16'(res.len));
    put(16'h0250, oag_pkg::PFX_INDIRECT);
    put(16'h0251, 8'h20);
    put(16'h0252, 8'h70);
    put(16'h0070, 8'hFE);
    run(16'h0250, 8'h00, 8'h00);
    chk("rel ind target", 16'h0251, res.target);
    chk("rel ind mode", 16'(oag_pkg::M_REL_IND), 16'(res.mode));
    put(16'h0260, oag_pkg::PFX_INDIRECT);
    put(16'h0261, 8'h10);
    put(16'h0262, 8'h71);
    put(16'h0071, 8'h44);
    run(16'h0260, 8'h00, 8'h00);
    chk("bit ind ea", 16'h0044, res.ea);
    put(16'h0270, oag_pkg::PFX_INDIRECT);
    put(16'h0271, 8'h00);
    put(16'h0272, 8'h72);
    put(16'h0273, 8'h05);
    put(16'h0072, 8'h99);
    run(16'h0270, 8'h00, 8'h00);
    chk("bitrel ind ea", 16'h0099, res.ea);
    chk("bitrel ind target", 16'h0279, res.target);
    chk("bitrel ind takes", 16'h0005, 16'(takes));
  endtask : s_ind_more

  // Reset lands in the cycle a slow fetch's byte arrives, before it is taken
  task automatic s_mid_reset;
    slow = 1'b1;
    put(16'h0280, 8'hC6);
    start_in = 1'b1;
    req_in = {16'h0280, 8'h00, 8'h00};
    @(posedge clk_in);
    #1;
    start_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    reset_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    slow = 1'b0;
    chk("req in reset", 16'h0000, {15'h0000, mem_req});
    chk("busy in reset", 16'h0000, {15'h0000, busy});
    chk("ea in reset", 16'h0000, res.ea);
    @(posedge clk_in);
    #1;
    chk("done after release", 16'h0000, {15'h0000, done});
    chk("req after release", 16'h0000, {15'h0000, mem_req});
    put(16'h0290, 8'h40);
    run(16'h0290, 8'h00, 8'h00);
    chk("inh len after reset", 16'h0001, 16'(res.len));
    chk("inh takes after reset", 16'h0001, 16'(takes));
  endtask : s_mid_reset

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    s_reset();
    s_inh_imm();
    s_direct();
    s_indexed();
    s_indirect();
    s_relative();
    s_bit();
    s_ind_more();
    s_mid_reset();
    test_done();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    error_cnt++;
    test_done();
  end
endmodule : cpu_operand_address_generator_bench

// ### tb/oag_mem_model.sv
// Program and data memory seen by the operand address generator
`timescale 1ns/10ps
module oag_mem_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic mem_req_in,
  input wire logic [15:0] mem_addr_in,
  output logic [7:0] mem_rdata_out,
  output logic mem_valid_out
);
  // ---------------------------------------------------------------
  // Storage and answer timing
  // ---------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [1:0] wait_cnt;
  int n_take;
  logic [15:0] last_addr;

  initial begin
    mem_rdata_out = 8'h00;
    mem_valid_out = 1'b0;
    wait_cnt = 2'h0;
    n_take = 0;
    last_addr = 16'h0000;
  end

  // Counted mid-cycle so the design's edge updates cannot race it
  always @(negedge clk_in) begin
    if (mem_req_in && mem_valid_out) begin
      n_take = n_take + 1;
      last_addr = mem_addr_in;
    end
  end

  always @(posedge clk_in) begin
    #1;
    if (mem_req_in && (!slow_in || wait_cnt == 2'h3)) begin
      mem_valid_out = 1'b1;
      mem_rdata_out = mem[mem_addr_in];
      wait_cnt = 2'h0;
    end else begin
      // Released bus inverts its byte each cycle, so the stale byte shows on alternate cycles
      mem_valid_out = 1'b0;
      mem_rdata_out = ~mem_rdata_out;
      wait_cnt = mem_req_in ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule : oag_mem_model
